/* microstep_current_translator.v */
// Micro-step current translator with winding duty monitors and an AHB-Lite register slave.
//
// The implementer's own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "microstep_translator_consts.vh"

// ****************************************
// Per-winding duty measurement and top regulation
// ****************************************
module winding_monitor #(
   parameter PERIOD = `PWM_PERIOD_CYCLES
)(
   input wire clk,
   input wire reset_n,
   input wire pwm_on,
   input wire current_reached,
   output reg [8:0] duty,
   output reg top_reg
);
   localparam [31:0] LAST_WIDE = PERIOD - 1;
   localparam [31:0] TOP_LIMIT_WIDE = (PERIOD * `TOP_REG_PERCENT) / 100;
   localparam [8:0] LAST = LAST_WIDE[8:0];
   localparam [8:0] TOP_LIMIT = TOP_LIMIT_WIDE[8:0];
   reg [8:0] phase;
   reg [8:0] on_count;
   reg reached_in_time;

   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         phase <= 9'h000;
         on_count <= 9'h000;
         reached_in_time <= 1'b0;
         duty <= 9'h000;
         top_reg <= 1'b0;
      end
      else
      begin
         if (phase == LAST)
         begin
            phase <= 9'h000;
            on_count <= 9'h000;
            reached_in_time <= 1'b0;
            duty <= on_count + {8'h00, pwm_on};
            if (reached_in_time)
            begin
               top_reg <= 1'b0;
            end
         end
         else
         begin
            phase <= phase + 9'h001;
            on_count <= on_count + {8'h00, pwm_on};
            if (current_reached && phase < TOP_LIMIT)
            begin
               reached_in_time <= 1'b1;
            end
            if (phase == TOP_LIMIT && !reached_in_time)
            begin
               top_reg <= 1'b1;
            end
         end
      end
   end
endmodule

// ****************************************
// Translator top level
// ****************************************
module microstep_current_translator #(
   parameter PWM_PERIOD = `PWM_PERIOD_CYCLES
)(
   // Clock and reset
   input wire CLK_I,
   input wire RESET_N_I,
   // AHB-Lite slave
   input wire HSEL_I,
   input wire [31:0] HADDR_I,
   input wire [1:0] HTRANS_I,
   input wire HWRITE_I,
   input wire [2:0] HSIZE_I,
   input wire [31:0] HWDATA_I,
   input wire HREADY_I,
   output reg [31:0] HRDATA_O,
   output reg HREADYOUT_O,
   output reg HRESP_O,
   // Motion pins
   input wire STEP_PULSE_PIN_I,
   input wire DIR_PIN_I,
   input wire RUN_HOLD_PIN_I,
   // Bridge feedback
   input wire PWM_X_ON_I,
   input wire PWM_Y_ON_I,
   input wire CURRENT_REACHED_X_I,
   input wire CURRENT_REACHED_Y_I,
   // Set points and regulation
   output reg [10:0] SETPOINT_X_O,
   output reg [10:0] SETPOINT_Y_O,
   output reg TOP_REG_X_O,
   output reg TOP_REG_Y_O,
   output reg [5:0] POSITION_O
);
   reg [2:0] step_resolution_select;
   reg rotation_polarity_bit;
   reg run_hold_polarity_bit;
   reg step_command_bit;
   reg [5:0] translator_position;
   reg step_pin_last;
   reg align_pending;
   reg swap_pending;
   reg align_second;
   reg bus_write;
   reg [7:0] bus_addr;
   wire [8:0] duty_x;
   wire [8:0] duty_y;
   wire top_x;
   wire top_y;
   wire direction;
   wire run_mode;
   wire trigger;
   wire bus_access;
   reg [5:0] step_size;
   reg [5:0] next_position;
   reg [5:0] realigned;
   reg next_align;
   reg next_swap;
   reg next_second;
   reg [10:0] next_set_x;
   reg [10:0] next_set_y;
   reg [31:0] next_rdata;

   // ****************************************
   // Sine lookup, tenths of a percent
   // ****************************************
   function [9:0] quarter_sine;
      input [4:0] idx;
      begin
         case (idx)
            5'h00: quarter_sine = 10'd0;
            5'h01: quarter_sine = 10'd98;
            5'h02: quarter_sine = 10'd195;
            5'h03: quarter_sine = 10'd290;
            5'h04: quarter_sine = 10'd383;
            5'h05: quarter_sine = 10'd471;
            5'h06: quarter_sine = 10'd556;
            5'h07: quarter_sine = 10'd634;
            5'h08: quarter_sine = 10'd707;
            5'h09: quarter_sine = 10'd773;
            5'h0A: quarter_sine = 10'd831;
            5'h0B: quarter_sine = 10'd882;
            5'h0C: quarter_sine = 10'd924;
            5'h0D: quarter_sine = 10'd957;
            5'h0E: quarter_sine = 10'd981;
            5'h0F: quarter_sine = 10'd995;
            default: quarter_sine = 10'd1000;
         endcase
      end
   endfunction

   function [10:0] signed_sine;
      input [5:0] pos;
      reg [9:0] mag;
      begin
         mag = 10'd0;
         if (pos[4])
         begin
            mag = quarter_sine(5'h10 - {1'b0, pos[3:0]});
         end
         else
         begin
            mag = quarter_sine({1'b0, pos[3:0]});
         end
         if (pos[5])
         begin
            signed_sine = 11'h000 - {1'b0, mag};
         end
         else
         begin
            signed_sine = {1'b0, mag};
         end
      end
   endfunction

   function [10:0] full_dual_level;
      input [10:0] level;
      begin
         if (level[10])
         begin
            full_dual_level = 11'h000 - `DUAL_FULL_STEP_LEVEL;
         end
         else
         begin
            full_dual_level = `DUAL_FULL_STEP_LEVEL;
         end
      end
   endfunction

   function is_full;
      input [2:0] res;
      begin
         is_full = (res == `RES_FULL_SINGLE) || (res == `RES_FULL_DUAL);
      end
   endfunction

   // Unused low position bits of each resolution.
   function [3:0] coarse_mask;
      input [2:0] res;
      begin
         case (res)
            `RES_EIGHTH: coarse_mask = 4'h1;
            `RES_QUARTER: coarse_mask = 4'h3;
            `RES_HALF: coarse_mask = 4'h7;
            `RES_FULL_SINGLE: coarse_mask = 4'hF;
            `RES_FULL_DUAL: coarse_mask = 4'hF;
            default: coarse_mask = 4'h0;
         endcase
      end
   endfunction

   // ****************************************
   // Winding monitors
   // ****************************************
   winding_monitor #(.PERIOD(PWM_PERIOD)) monitor_x (
      .clk(CLK_I),
      .reset_n(RESET_N_I),
      .pwm_on(PWM_X_ON_I),
      .current_reached(CURRENT_REACHED_X_I),
      .duty(duty_x),
      .top_reg(top_x)
   );

   winding_monitor #(.PERIOD(PWM_PERIOD)) monitor_y (
      .clk(CLK_I),
      .reset_n(RESET_N_I),
      .pwm_on(PWM_Y_ON_I),
      .current_reached(CURRENT_REACHED_Y_I),
      .duty(duty_y),
      .top_reg(top_y)
   );

   // ****************************************
   // Step decision
   // ****************************************
   assign direction = DIR_PIN_I ^ rotation_polarity_bit;
   assign run_mode = RUN_HOLD_PIN_I ^ run_hold_polarity_bit;
   assign trigger = (STEP_PULSE_PIN_I & ~step_pin_last) | step_command_bit;
   assign bus_access = HSEL_I & HREADY_I & HTRANS_I[1];

   always @*
   begin
      case (step_resolution_select)
         `RES_EIGHTH: step_size = 6'h02;
         `RES_QUARTER: step_size = 6'h04;
         `RES_HALF: step_size = 6'h08;
         `RES_FULL_SINGLE: step_size = 6'h10;
         `RES_FULL_DUAL: step_size = 6'h10;
         default: step_size = 6'h01;
      endcase
      realigned = {translator_position[5:4], 4'h8};
      next_position = translator_position;
      next_align = align_pending;
      next_swap = swap_pending;
      next_second = align_second;
      if (run_mode && trigger)
      begin
         next_align = 1'b0;
         next_swap = 1'b0;
         next_second = 1'b0;
         if (swap_pending)
         begin
            if (direction)
            begin
               next_position = translator_position + 6'h08;
            end
            else
            begin
               next_position = translator_position - 6'h08;
            end
         end
         else if (align_pending)
         begin
            if (direction)
            begin
               next_position = realigned;
            end
            else if (!align_second)
            begin
               next_position = {translator_position[5:4], 4'h0};
               next_align = 1'b1;
               next_second = 1'b1;
            end
            else
            begin
               next_position = realigned - 6'h10;
            end
         end
         else if (direction)
         begin
            next_position = translator_position + step_size;
         end
         else
         begin
            next_position = translator_position - step_size;
         end
      end
   end

   // ****************************************
   // Set points
   // ****************************************
   always @*
   begin
      next_set_y = signed_sine(translator_position);
      next_set_x = signed_sine(translator_position + 6'h10);
      if (step_resolution_select == `RES_FULL_DUAL)
      begin
         next_set_y = full_dual_level(next_set_y);
         next_set_x = full_dual_level(next_set_x);
      end
   end

   // ****************************************
   // Read data
   // ****************************************
   always @*
   begin
      case (HADDR_I[7:0])
         `CTRL_OFFSET: next_rdata = {26'h0000000, step_command_bit, run_hold_polarity_bit,
            rotation_polarity_bit, step_resolution_select};
         `POSITION_OFFSET: next_rdata = {24'h000000, DIR_PIN_I, run_mode, translator_position};
         `COIL_X_STATUS_OFFSET: next_rdata = {5'h00, SETPOINT_X_O, 6'h00, top_x, duty_x};
         `COIL_Y_STATUS_OFFSET: next_rdata = {5'h00, SETPOINT_Y_O, 6'h00, top_y, duty_y};
         default: next_rdata = 32'h00000000;
      endcase
   end

   // ****************************************
   // Registers, bus and translator state
   // ****************************************
   always @(posedge CLK_I)
   begin
      if (!RESET_N_I)
      begin
         step_resolution_select <= `RESET_RESOLUTION;
         translator_position <= `RESET_POSITION;
         rotation_polarity_bit <= 1'b0;
         run_hold_polarity_bit <= 1'b0;
         step_command_bit <= 1'b0;
         step_pin_last <= 1'b0;
         align_pending <= 1'b0;
         swap_pending <= 1'b0;
         align_second <= 1'b0;
         bus_write <= 1'b0;
         bus_addr <= 8'h00;
         HRDATA_O <= 32'h00000000;
         HREADYOUT_O <= 1'b1;
         HRESP_O <= 1'b0;
         SETPOINT_X_O <= 11'h000;
         SETPOINT_Y_O <= 11'h000;
         TOP_REG_X_O <= 1'b0;
         TOP_REG_Y_O <= 1'b0;
         POSITION_O <= `RESET_POSITION;
      end
      else
      begin
         HREADYOUT_O <= 1'b1;
         HRESP_O <= 1'b0;
         step_pin_last <= STEP_PULSE_PIN_I;
         bus_write <= bus_access & HWRITE_I;
         bus_addr <= HADDR_I[7:0];
         if (bus_access && !HWRITE_I)
         begin
            HRDATA_O <= next_rdata;
         end
         SETPOINT_X_O <= next_set_x;
         SETPOINT_Y_O <= next_set_y;
         TOP_REG_X_O <= top_x;
         TOP_REG_Y_O <= top_y;
         POSITION_O <= translator_position;
         if (bus_write && bus_addr == `CTRL_OFFSET)
         begin
            step_resolution_select <= HWDATA_I[`CTRL_RESOLUTION_LSB+2:`CTRL_RESOLUTION_LSB];
            rotation_polarity_bit <= HWDATA_I[`CTRL_ROTATION_POL_BIT];
            run_hold_polarity_bit <= HWDATA_I[`CTRL_RUN_HOLD_POL_BIT];
            step_command_bit <= HWDATA_I[`CTRL_STEP_COMMAND_BIT];
            translator_position <= translator_position;
            align_pending <= 1'b0;
            swap_pending <= 1'b0;
            align_second <= 1'b0;
            if (is_full(step_resolution_select) &&
               HWDATA_I[2:0] != step_resolution_select && is_full(HWDATA_I[2:0]))
            begin
               swap_pending <= 1'b1;
            end
            else if (HWDATA_I[2:0] == `RES_FULL_DUAL && !is_full(step_resolution_select))
            begin
               if (translator_position[3])
               begin
                  translator_position <= realigned;
               end
               else
               begin
                  align_pending <= 1'b1;
               end
            end
            else if (coarse_mask(HWDATA_I[2:0]) > coarse_mask(step_resolution_select))
            begin
               translator_position <= {translator_position[5:4],
                  translator_position[3:0] & ~coarse_mask(HWDATA_I[2:0])};
            end
            else
            begin
               translator_position <= translator_position;
            end
         end
         else
         begin
            if (trigger)
            begin
               step_command_bit <= 1'b0;
            end
            translator_position <= next_position;
            align_pending <= next_align;
            swap_pending <= next_swap;
            align_second <= next_second;
         end
      end
   end
endmodule

/* microstep_translator_consts.vh */
// Constants for the micro-step current translator: offsets, fields, reset values, timing.
`ifndef MICROSTEP_TRANSLATOR_CONSTS_VH
`define MICROSTEP_TRANSLATOR_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define CTRL_OFFSET 8'h00
`define POSITION_OFFSET 8'h04
`define COIL_X_STATUS_OFFSET 8'h08
`define COIL_Y_STATUS_OFFSET 8'h0C

// ****************************************
// Control register fields
// ****************************************
`define CTRL_RESOLUTION_LSB 0
`define CTRL_ROTATION_POL_BIT 3
`define CTRL_RUN_HOLD_POL_BIT 4
`define CTRL_STEP_COMMAND_BIT 5

// ****************************************
// Step resolution codes
// ****************************************
`define RES_SIXTEENTH 3'h0
`define RES_EIGHTH 3'h1
`define RES_QUARTER 3'h2
`define RES_HALF 3'h3
`define RES_FULL_SINGLE 3'h5
`define RES_FULL_DUAL 3'h7

// ****************************************
// Reset values, timing and set-point levels
// ****************************************
`define RESET_RESOLUTION 3'h0
`define RESET_POSITION 6'h08
`define PWM_PERIOD_CYCLES 256
`define TOP_REG_PERCENT 75
`define DUAL_FULL_STEP_LEVEL 11'h2C6
`define SINE_PEAK_LEVEL 11'h3E8

`endif

/* microstep_translator_props.sv */
// Concurrent checks on the ports of the micro-step current translator.
`timescale 1ns/10ps
module microstep_translator_props #(
   parameter PWM_PERIOD = 256
)(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   // Bus
   input wire logic HSEL_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HREADY_I,
   input wire logic HREADYOUT_O,
   input wire logic HRESP_O,
   // Motion and feedback
   input wire logic STEP_PULSE_PIN_I,
   input wire logic CURRENT_REACHED_X_I,
   // Set points and regulation
   input wire logic [10:0] SETPOINT_X_O,
   input wire logic [10:0] SETPOINT_Y_O,
   input wire logic TOP_REG_X_O,
   input wire logic [5:0] POSITION_O
);
   localparam int LIM = 3 * PWM_PERIOD;
   logic [11:0] quiet;
   logic [11:0] low_x;
   logic [11:0] high_x;
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RESET_N_I);
   always @(posedge CLK_I)
      if (!RESET_N_I)
      begin
         quiet <= 12'h000;
         low_x <= 12'h000;
         high_x <= 12'h000;
      end
      else
      begin
         quiet <= (STEP_PULSE_PIN_I || (HSEL_I && HREADY_I && HTRANS_I[1])) ? 12'h000 :
            quiet + {11'h000, quiet < 12'h800};
         low_x <= CURRENT_REACHED_X_I ? 12'h000 : low_x + {11'h000, low_x < 12'h800};
         high_x <= CURRENT_REACHED_X_I ? high_x + {11'h000, high_x < 12'h800} : 12'h000;
      end
   a_bus_always_ok: assert property (HREADYOUT_O && !HRESP_O)
      else $error("bus answer not ready and okay");
   a_reset_home_pos: assert property ($rose(RESET_N_I) |-> POSITION_O == 6'h08)
      else $error("position not 8 after reset");
   a_reset_setpoint: assert property ($rose(RESET_N_I) |-> ##2
      (SETPOINT_X_O == 11'h2C3 && SETPOINT_Y_O == 11'h2C3))
      else $error("set points not 70.7 after reset");
   a_move_has_cause: assert property ($changed(POSITION_O) |-> quiet < 12'h008)
      else $error("position moved without a trigger");
   a_zero_setpoint: assert property (POSITION_O == 6'h00 |->
      SETPOINT_Y_O == 11'h000 && SETPOINT_X_O == 11'h3E8)
      else $error("wrong set points at position 0");
   a_quarter_setpoint: assert property (POSITION_O == 6'h10 |->
      SETPOINT_Y_O == 11'h3E8 && SETPOINT_X_O == 11'h000)
      else $error("wrong set points at position 16");
   a_top_x_sets: assert property (low_x >= LIM |-> TOP_REG_X_O)
      else $error("top regulation not entered");
   a_top_x_clears: assert property (high_x >= LIM |-> !TOP_REG_X_O)
      else $error("top regulation not left");
   c_pos_zero: cover property (POSITION_O == 6'h00);
   c_top_rise: cover property ($rose(TOP_REG_X_O));
   c_dual_full: cover property (SETPOINT_X_O == 11'h53A);
endmodule

/* step_source.sv */
// Step pulse source standing in for the controller that drives the step pin.
`timescale 1ns/10ps
module step_source (
   // Clock, reset and request
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic [5:0] count_i,
   input wire logic [3:0] gap_i,
   // Pin and status
   output logic step_o,
   output logic busy_o
);
   logic [5:0] left;
   logic [3:0] wait_c;
   assign busy_o = (left != 6'h00) || (wait_c != 4'h0) || step_o;
   always @(posedge clk_i)
      if (!rst_n_i)
      begin
         left <= 6'h00;
         wait_c <= 4'h0;
         step_o <= 1'b0;
      end
      else if (start_i && !busy_o)
         left <= count_i;
      else if (step_o)
      begin
         step_o <= 1'b0;
         wait_c <= gap_i;
      end
      else if (wait_c != 4'h0)
         wait_c <= wait_c - 4'h1;
      else if (left != 6'h00)
      begin
         step_o <= 1'b1;
         left <= left - 6'h01;
      end
endmodule

/* microstep_current_translator_tb.sv */
// Self-checking bench for the micro-step current translator.
`timescale 1ns/10ps
module microstep_current_translator_tb;
   localparam int P = 16;
   logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, dir = 1, rh = 1, start = 0, rd_pend = 0;
   logic pwx = 0, pwy = 0, rcx = 1, rcy = 1;
   logic [1:0] htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0;
   logic [5:0] cnt = 0;
   logic [3:0] gap = 0;
   logic [31:0] exp_q[$], msk_q[$];
   wire step, busy, hready, hresp, topx, topy;
   wire [31:0] hrdata;
   wire [10:0] spx, spy;
   wire [5:0] pos;
   int err_count = 0, check_count = 0, n, pe;
   microstep_current_translator #(.PWM_PERIOD(P)) u_dut (.CLK_I(clk), .RESET_N_I(rst_n),
      .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
      .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
      .HRESP_O(hresp), .STEP_PULSE_PIN_I(step), .DIR_PIN_I(dir), .RUN_HOLD_PIN_I(rh),
      .PWM_X_ON_I(pwx), .PWM_Y_ON_I(pwy), .CURRENT_REACHED_X_I(rcx), .CURRENT_REACHED_Y_I(rcy),
      .SETPOINT_X_O(spx), .SETPOINT_Y_O(spy), .TOP_REG_X_O(topx), .TOP_REG_Y_O(topy),
      .POSITION_O(pos));
   step_source u_src (.clk_i(clk), .rst_n_i(rst_n), .start_i(start), .count_i(cnt),
      .gap_i(gap), .step_o(step), .busy_o(busy));
   initial
   begin
      forever #20 clk = ~clk;
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic to_fail(input string s);
      err_count++;
      $display("BAD %0t %s", $time, s);
      report_and_stop();
   endtask
   task automatic tend(input string s);
      $display("test %s done", s);
   endtask
   function automatic logic [10:0] sn(input logic [5:0] p);
      logic [10:0] t [0:16];
      logic [10:0] v;
      t = '{11'h000, 11'h062, 11'h0C3, 11'h122, 11'h17F, 11'h1D7, 11'h22C, 11'h27A, 11'h2C3,
         11'h305, 11'h33F, 11'h372, 11'h39C, 11'h3BD, 11'h3D5, 11'h3E3, 11'h3E8};
      v = p[4] ? t[5'h10 - {1'b0, p[3:0]}] : t[p[3:0]];
      return p[5] ? -v : v;
   endfunction
   task automatic wait_rdy;
      int k;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (hready !== 1'b1 && k < 50);
      if (hready !== 1'b1)
         to_fail("bus wait timed out");
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h000000, a};
      wait_rdy();
      rd_pend <= !w;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd_pend <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      exp_q.push_back(e);
      msk_q.push_back(m);
      xfer(1'b0, a, 32'h00000000);
   endtask
   task automatic ctrl(input logic [5:0] v);
      xfer(1'b1, 8'h00, {26'h0000000, v});
   endtask
   task automatic chkpos(input int p);
      rd(8'h04, 32'h0000003F, {26'h0000000, p[5:0]});
   endtask
   task automatic chksp(input logic [10:0] x, input logic [10:0] y);
      rd(8'h08, 32'h07FF0000, {5'h00, x, 16'h0000});
      rd(8'h0C, 32'h07FF0000, {5'h00, y, 16'h0000});
   endtask
   task automatic chktop(input logic x, input logic y);
      check_count++;
      if (topx !== x || topy !== y)
      begin
         err_count++;
         $display("BAD %0t top flags %b%b expected %b%b", $time, topx, topy, x, y);
      end
   endtask
   task automatic steps(input int k);
      int t;
      @(posedge clk);
      start <= 1'b1;
      cnt <= 6'(k);
      gap <= 4'($urandom_range(3, 0));
      @(posedge clk);
      start <= 1'b0;
      t = 0;
      do
      begin
         @(posedge clk);
         t++;
      end
      while (busy === 1'b1 && t < 1000);
      if (busy !== 1'b0)
         to_fail("step source stuck");
      repeat (2) @(posedge clk);
   endtask
   always @(posedge clk)
      if (rd_pend && hready === 1'b1 && exp_q.size() > 0)
      begin
         check_count++;
         if ((hrdata & msk_q[0]) !== exp_q[0])
         begin
            err_count++;
            $display("BAD %0t read %h expected %h", $time, hrdata & msk_q[0], exp_q[0]);
         end
         exp_q.delete(0);
         msk_q.delete(0);
      end
   initial
   begin
      n = $urandom(47328);
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h00, 32'h0000003F, 32'h00000000);
      chkpos(8);
      chksp(11'h2C3, 11'h2C3);
      tend("reset");
      n = $urandom_range(8, 1);
      steps(n);
      chkpos(8 + n);
      chksp(sn(6'(24 + n)), sn(6'(8 + n)));
      dir <= 1'b0;
      steps(9 + n);
      chkpos(63);
      dir <= 1'b1;
      steps(1);
      chkpos(0);
      chksp(sn(6'h10), sn(6'h00));
      tend("sixteenth");
      ctrl(6'h08);
      steps(2);
      chkpos(62);
      ctrl(6'h28);
      repeat (4) @(posedge clk);
      rd(8'h00, 32'h0000003F, 32'h00000008);
      chkpos(61);
      ctrl(6'h00);
      rh <= 1'b0;
      steps(3);
      chkpos(61);
      rd(8'h04, 32'h000000C0, 32'h00000080);
      ctrl(6'h10);
      steps(2);
      chkpos(63);
      ctrl(6'h00);
      rh <= 1'b1;
      tend("direction and hold");
      steps(14);
      pe = 13;
      for (int r = 1; r < 4; r++)
      begin
         ctrl(6'(r));
         pe = pe & ~((1 << r) - 1);
         chkpos(pe);
         steps(1);
         pe = pe + (1 << r);
         chkpos(pe);
      end
      ctrl(6'h00);
      chkpos(24);
      steps(1);
      chkpos(25);
      tend("micro modes");
      ctrl(6'h05);
      chkpos(16);
      steps(1);
      chkpos(32);
      chksp(11'h418, 11'h000);
      ctrl(6'h07);
      steps(1);
      chkpos(40);
      chksp(11'h53A, 11'h53A);
      ctrl(6'h05);
      steps(1);
      chkpos(48);
      ctrl(6'h00);
      chkpos(48);
      dir <= 1'b0;
      ctrl(6'h07);
      steps(2);
      chkpos(40);
      ctrl(6'h00);
      steps(1);
      chkpos(39);
      dir <= 1'b1;
      ctrl(6'h07);
      steps(1);
      chkpos(40);
      tend("full step");
      pwx <= 1'b1;
      rcx <= 1'b0;
      repeat (4 * P) @(posedge clk);
      rd(8'h08, 32'h000003FF, 32'h00000210);
      rd(8'h0C, 32'h000003FF, 32'h00000000);
      chktop(1'b1, 1'b0);
      pwx <= 1'b0;
      rcx <= 1'b1;
      pwy <= 1'b1;
      rcy <= 1'b0;
      repeat (4 * P) @(posedge clk);
      rd(8'h08, 32'h000003FF, 32'h00000000);
      rd(8'h0C, 32'h000003FF, 32'h00000210);
      chktop(1'b0, 1'b1);
      tend("duty");
      report_and_stop();
   end
endmodule
bind microstep_current_translator microstep_translator_props #(.PWM_PERIOD(PWM_PERIOD)) u_props (
   .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .HSEL_I(HSEL_I), .HTRANS_I(HTRANS_I),
   .HREADY_I(HREADY_I), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
   .STEP_PULSE_PIN_I(STEP_PULSE_PIN_I), .CURRENT_REACHED_X_I(CURRENT_REACHED_X_I),
   .SETPOINT_X_O(SETPOINT_X_O), .SETPOINT_Y_O(SETPOINT_Y_O), .TOP_REG_X_O(TOP_REG_X_O),
   .POSITION_O(POSITION_O));
